// file: design/tmw_timer_irq.sv
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module tmw_timer_irq #(
  parameter int W = tmw_pkg::DATA_W
) (
  input  wire logic                  mclk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  ce_in,
  input  wire tmw_pkg::tmw_bus_req_t bus_req_in,
  output logic      [W-1:0]          rd_data_out,
  input  wire logic [3:0]            capture_compare_pin_in,
  output logic                       capture_compare_pin_a_out,
  output logic                       capture_compare_pin_a_oe_out,
  output logic                       overflow_irq_out,
  output logic                       match_irq_a_out,
  output logic                       match_irq_b_out,
  output logic                       match_irq_c_out,
  output logic                       match_irq_d_out,
  output logic                       timer_irq_out
);

  localparam int NCH = tmw_pkg::NUM_CH;
  localparam int NFL = tmw_pkg::NUM_FLAGS;
  // General register offsets, channel A first
  localparam logic [tmw_pkg::ADDR_W-1:0] GR_OFF [NCH] = '{
    tmw_pkg::OFF_GR_A, tmw_pkg::OFF_GR_B,
    tmw_pkg::OFF_GR_C, tmw_pkg::OFF_GR_D
  };

  // Register state
  logic                       initial_level_ch_a;
  tmw_pkg::tmw_out_act_t      act_a;
  logic                       counter_run;
  logic                       overflow_irq_en;
  logic [NCH-1:0]             match_irq_en;
  logic [NCH-1:0]             capture_mode;
  logic [NCH-1:0]             falling_sel;
  logic [W-1:0]               timer_counter_value;
  logic                       pin_a_level;
  logic                       next_pin_a;
  logic [NCH-1:0]             match_irq;

  // Flags: bits 3..0 match D..A, bit 4 overflow
  logic [NFL-1:0]             flag;
  logic [NFL-1:0]             flag_event;
  logic [NFL-1:0]             flag_en;
  logic [NFL-1:0]             clr_ok;
  tmw_pkg::tmw_clr_state_t    clr_state [NFL];

  // Bus decode
  logic                       wr;
  logic                       rd;
  logic [tmw_pkg::ADDR_W-1:0] addr;
  logic [W-1:0]               wdata;
  logic                       wr_ctrl;
  logic                       wr_en;
  logic                       wr_status;
  logic                       rd_status;
  logic                       wr_count;
  logic                       wr_mode;
  logic [NCH-1:0]             wr_gr;
  logic [W-1:0]               gr [NCH];
  logic [NCH-1:0]             ch_event;
  logic                       ovf_event;
  logic [7:0]                 status_view;
  logic [7:0]                 en_view;
  logic [7:0]                 ctrl_view;
  logic [7:0]                 mode_view;
  logic [W-1:0]               next_rd_data;

  assign wr    = bus_req_in.wr;
  assign rd    = bus_req_in.rd;
  assign addr  = bus_req_in.addr;
  assign wdata = bus_req_in.wdata;

  assign wr_ctrl   = wr && (addr == tmw_pkg::OFF_OUT_CTRL);
  assign wr_en     = wr && (addr == tmw_pkg::OFF_IRQ_EN);
  assign wr_status = wr && (addr == tmw_pkg::OFF_STATUS);
  assign rd_status = rd && (addr == tmw_pkg::OFF_STATUS);
  assign wr_count  = wr && (addr == tmw_pkg::OFF_COUNT);
  assign wr_mode   = wr && (addr == tmw_pkg::OFF_CH_MODE);
  for (genvar c = 0; c < NCH; c++) begin : g_gr_dec
    assign wr_gr[c] = wr && (addr == GR_OFF[c]);
  end

  // Initial level of channel A
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      initial_level_ch_a <= 1'b0;
    end else if (ce_in && wr_ctrl) begin
      initial_level_ch_a <= wdata[tmw_pkg::CTRL_LEVEL_BIT];
    end
  end

  // Action taken on a channel A match
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      act_a <= tmw_pkg::ACT_NONE;
    end else if (ce_in && wr_ctrl) begin
      act_a <= tmw_pkg::tmw_out_act_t'(
                 wdata[tmw_pkg::CTRL_ACT_LSB +: 2]);
    end
  end

  // Counter run bit
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      counter_run <= 1'b0;
    end else if (ce_in && wr_ctrl) begin
      counter_run <= wdata[tmw_pkg::CTRL_RUN_BIT];
    end
  end

  // Overflow enable; reserved bits keep no state
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      overflow_irq_en <= 1'b0;
    end else if (ce_in && wr_en) begin
      overflow_irq_en <= wdata[tmw_pkg::OVF_BIT];
    end
  end

  // Match enables, one bit per channel
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      match_irq_en <= '0;
    end else if (ce_in && wr_en) begin
      match_irq_en <= wdata[tmw_pkg::MATCH_LSB +: NCH];
    end
  end

  // Capture mode per channel
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      capture_mode <= '0;
    end else if (ce_in && wr_mode) begin
      capture_mode <= wdata[tmw_pkg::MODE_CAP_LSB +: NCH];
    end
  end

  // Capture edge per channel, falling when set
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      falling_sel <= '0;
    end else if (ce_in && wr_mode) begin
      falling_sel <= wdata[tmw_pkg::MODE_FALL_LSB +: NCH];
    end
  end

  // Free-running counter
  // A counter write wins, so no overflow in that cycle
  assign ovf_event = ce_in && counter_run && !wr_count &&
                     (timer_counter_value == tmw_pkg::CNT_MAX);

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      timer_counter_value <= tmw_pkg::CNT_RESET;
    end else if (ce_in) begin
      if (wr_count) begin
        timer_counter_value <= wdata;
      end else if (counter_run) begin
        timer_counter_value <= W'(timer_counter_value + 1'b1);
      end
    end
  end

  // Compare/capture channels
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    tmw_channel #(
      .W (W)
    ) u_ch (
      .mclk_in         (mclk_in),
      .sys_rst_in      (sys_rst_in),
      .ce_in           (ce_in),
      .pin_in          (capture_compare_pin_in[c]),
      .capture_mode_in (capture_mode[c]),
      .falling_in      (falling_sel[c]),
      .run_in          (counter_run),
      .count_in        (timer_counter_value),
      .gr_wr_in        (wr_gr[c]),
      .gr_wdata_in     (wdata),
      .gr_out          (gr[c]),
      .event_out       (ch_event[c])
    );
  end

  assign flag_event = {ovf_event, ch_event};
  assign flag_en    = {overflow_irq_en, match_irq_en};

  // Flags with read-one-then-write-zero clearing; a new event wins
  for (genvar f = 0; f < NFL; f++) begin : g_flag
    localparam int SBIT = (f == tmw_pkg::FLAG_OVF) ? tmw_pkg::OVF_BIT
                                                   : tmw_pkg::MATCH_LSB + f;

    // Zero written while armed clears this flag
    assign clr_ok[f] = wr_status && !wdata[SBIT] &&
                       (clr_state[f] == tmw_pkg::CLR_ARMED);

    always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
        flag[f] <= 1'b0;
      end else if (ce_in) begin
        if (flag_event[f]) begin
          flag[f] <= 1'b1;
        end else if (clr_ok[f]) begin
          flag[f] <= 1'b0;
        end
      end
    end

    // Arm is lost on any status write or when the flag drops
    always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
        clr_state[f] <= tmw_pkg::CLR_IDLE;
      end else if (ce_in) begin
        case (clr_state[f])
          tmw_pkg::CLR_IDLE: begin
            if (rd_status && flag[f]) begin
              clr_state[f] <= tmw_pkg::CLR_ARMED;
            end
          end
          tmw_pkg::CLR_ARMED: begin
            if (wr_status || !flag[f]) begin
              clr_state[f] <= tmw_pkg::CLR_IDLE;
            end
          end
          default: clr_state[f] <= tmw_pkg::CLR_IDLE;
        endcase
      end
    end
  end

  // Level that a compare match on channel A leaves on the pin
  always_comb begin
    case (act_a)
      tmw_pkg::ACT_NONE:   next_pin_a = pin_a_level;
      tmw_pkg::ACT_LOW:    next_pin_a = 1'b0;
      tmw_pkg::ACT_HIGH:   next_pin_a = 1'b1;
      tmw_pkg::ACT_TOGGLE: next_pin_a = !pin_a_level;
      default:             next_pin_a = pin_a_level;
    endcase
  end

  // Channel A pin level; a control write wins over a match
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pin_a_level <= 1'b0;
    end else if (ce_in) begin
      if (wr_ctrl) begin
        pin_a_level <= wdata[tmw_pkg::CTRL_LEVEL_BIT];
      end else if (ch_event[0] && !capture_mode[0]) begin
        pin_a_level <= next_pin_a;
      end
    end
  end

  assign capture_compare_pin_a_out    = pin_a_level;
  // Pin A is driven only in compare mode
  assign capture_compare_pin_a_oe_out = !capture_mode[0];

  // Interrupt requests
  assign overflow_irq_out =
    flag[tmw_pkg::FLAG_OVF] && overflow_irq_en;

  // One request per match channel
  for (genvar c = 0; c < NCH; c++) begin : g_irq
    assign match_irq[c] = flag[c] && match_irq_en[c];
  end

  assign match_irq_a_out = match_irq[0];
  assign match_irq_b_out = match_irq[1];
  assign match_irq_c_out = match_irq[2];
  assign match_irq_d_out = match_irq[3];
  assign timer_irq_out   = |(flag & flag_en);

  // Read views
  always_comb begin
    status_view = tmw_pkg::RSVD_ONES;
    status_view[tmw_pkg::OVF_BIT] = flag[tmw_pkg::FLAG_OVF];
    status_view[tmw_pkg::MATCH_LSB +: NCH] = flag[NCH-1:0];
  end

  always_comb begin
    en_view = tmw_pkg::RSVD_ONES;
    en_view[tmw_pkg::OVF_BIT] = overflow_irq_en;
    en_view[tmw_pkg::MATCH_LSB +: NCH] = match_irq_en;
  end

  always_comb begin
    ctrl_view = tmw_pkg::REG8_RESET;
    ctrl_view[tmw_pkg::CTRL_LEVEL_BIT] = initial_level_ch_a;
    ctrl_view[tmw_pkg::CTRL_ACT_LSB +: 2] = act_a;
    ctrl_view[tmw_pkg::CTRL_RUN_BIT] = counter_run;
  end

  always_comb begin
    mode_view = tmw_pkg::REG8_RESET;
    mode_view[tmw_pkg::MODE_CAP_LSB +: NCH] = capture_mode;
    mode_view[tmw_pkg::MODE_FALL_LSB +: NCH] = falling_sel;
  end

  always_comb begin
    next_rd_data = tmw_pkg::DATA_ZERO;
    if (rd) begin
      case (addr)
        tmw_pkg::OFF_OUT_CTRL: next_rd_data = W'(ctrl_view);
        tmw_pkg::OFF_IRQ_EN:   next_rd_data = W'(en_view);
        tmw_pkg::OFF_STATUS:   next_rd_data = W'(status_view);
        tmw_pkg::OFF_COUNT:    next_rd_data = timer_counter_value;
        tmw_pkg::OFF_GR_A:     next_rd_data = gr[0];
        tmw_pkg::OFF_GR_B:     next_rd_data = gr[1];
        tmw_pkg::OFF_GR_C:     next_rd_data = gr[2];
        tmw_pkg::OFF_GR_D:     next_rd_data = gr[3];
        tmw_pkg::OFF_CH_MODE:  next_rd_data = W'(mode_view);
        default:               next_rd_data = tmw_pkg::DATA_ZERO;
      endcase
    end
  end

  // Read data stand until the next enabled cycle, zero after an enabled cycle without a read
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rd_data_out <= tmw_pkg::DATA_ZERO;
    end else if (ce_in) begin
      rd_data_out <= next_rd_data;
    end
  end

endmodule : tmw_timer_irq

// file: design/tmw_pkg.sv
package tmw_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 4;
  localparam int NUM_FLAGS = 5;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tmw_bus_req_t;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_OUT_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_GR_A     = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_GR_B     = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_GR_C     = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_GR_D     = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_CH_MODE  = 8'h20;

  // Output control fields
  localparam int CTRL_LEVEL_BIT = 0;
  localparam int CTRL_ACT_LSB   = 1;
  localparam int CTRL_RUN_BIT   = 7;

  // Enable and status fields
  localparam int OVF_BIT = 7;
  localparam int MATCH_LSB = 0;
  localparam logic [7:0] RSVD_ONES = 8'h70;

  // Channel mode fields
  localparam int MODE_CAP_LSB  = 0;
  localparam int MODE_FALL_LSB = 4;

  // Flag index of the overflow flag in the flag vector
  localparam int FLAG_OVF = 4;

  localparam logic [DATA_W-1:0] CNT_MAX    = 16'hFFFF;
  localparam logic [DATA_W-1:0] CNT_RESET  = 16'h0000;
  localparam logic [DATA_W-1:0] GR_RESET   = 16'hFFFF;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 16'h0000;
  localparam logic [7:0]        REG8_RESET = 8'h00;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_LOW    = 2'b01,
    ACT_HIGH   = 2'b10,
    ACT_TOGGLE = 2'b11
  } tmw_out_act_t;

  typedef enum logic {
    CLR_IDLE  = 1'b0,
    CLR_ARMED = 1'b1
  } tmw_clr_state_t;

endpackage : tmw_pkg

// file: design/tmw_channel.sv
`timescale 1ns/1ps
module tmw_channel #(
  parameter int W = 16
) (
  input  wire logic         mclk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         ce_in,
  input  wire logic         pin_in,
  input  wire logic         capture_mode_in,
  input  wire logic         falling_in,
  input  wire logic         run_in,
  input  wire logic [W-1:0] count_in,
  input  wire logic         gr_wr_in,
  input  wire logic [W-1:0] gr_wdata_in,
  output logic      [W-1:0] gr_out,
  output logic              event_out
);

  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic edge_hit;
  logic match_hit;

  // Two-stage synchroniser, then edge history
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else if (ce_in) begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign edge_hit = capture_mode_in &&
                    (falling_in ? (pin_prev && !pin_sync)
                                : (!pin_prev && pin_sync));
  assign match_hit = !capture_mode_in && run_in && (count_in == gr_out);

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      gr_out <= tmw_pkg::GR_RESET[W-1:0];
    end else if (ce_in) begin
      if (edge_hit) begin
        gr_out <= count_in;
      end else if (gr_wr_in) begin
        gr_out <= gr_wdata_in;
      end
    end
  end

  assign event_out = ce_in && (edge_hit || match_hit);

endmodule : tmw_channel

// file: test/tmw_intc_model.sv
`timescale 1ns/1ps
module tmw_intc_model (
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       irq_in,
  output logic      [7:0] edges_out
);
  logic irq_q;

  // Level request seen as one event per rising edge
  always_ff @(posedge mclk_in) begin
    irq_q <= sys_rst_in ? 1'b0 : irq_in;
    if (sys_rst_in) edges_out <= 8'h00;
    else if (irq_in && !irq_q) edges_out <= edges_out + 8'h01;
  end
endmodule : tmw_intc_model

// file: test/tmw_timer_irq_monitor.sv
`timescale 1ns/1ps
module tmw_timer_irq_chk #(
  parameter int W = 16
) (
  input wire logic                  mclk_in,
  input wire logic                  sys_rst_in,
  input wire logic                  ce_in,
  input wire tmw_pkg::tmw_bus_req_t bus_req_in,
  input wire logic [W-1:0]          rd_data_out,
  input wire logic                  capture_compare_pin_a_out,
  input wire logic                  capture_compare_pin_a_oe_out,
  input wire logic                  overflow_irq_out,
  input wire logic                  match_irq_a_out,
  input wire logic                  match_irq_b_out,
  input wire logic                  match_irq_c_out,
  input wire logic                  match_irq_d_out,
  input wire logic                  timer_irq_out
);
  logic wr;
  logic en_wr;
  logic st_wr;
  logic [7:0] wd;
  assign wr = ce_in && bus_req_in.wr;
  assign wd = bus_req_in.wdata[7:0];
  assign en_wr = wr && bus_req_in.addr == tmw_pkg::OFF_IRQ_EN;
  assign st_wr = wr && bus_req_in.addr == tmw_pkg::OFF_STATUS;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  chk_irq_or_all: assert property (timer_irq_out == (overflow_irq_out |
    match_irq_a_out | match_irq_b_out | match_irq_c_out | match_irq_d_out))
    else $error("summary request not OR of requests");
  chk_ovf_mask: assert property (en_wr && !wd[7] |=> !overflow_irq_out)
    else $error("overflow request not masked");
  chk_d_mask: assert property (en_wr && !wd[3] |=> !match_irq_d_out)
    else $error("match d request not masked");
  chk_c_mask: assert property (en_wr && !wd[2] |=> !match_irq_c_out)
    else $error("match c request not masked");
  chk_b_mask: assert property (en_wr && !wd[1] |=> !match_irq_b_out)
    else $error("match b request not masked");
  chk_a_mask: assert property (en_wr && !wd[0] |=> !match_irq_a_out)
    else $error("match a request not masked");
  chk_rsvd_ones: assert property (ce_in && bus_req_in.rd &&
    bus_req_in.addr == tmw_pkg::OFF_IRQ_EN |=> rd_data_out[15:8] == 8'h00
    && rd_data_out[6:4] == 3'h7)
    else $error("enable reserved bits wrong");
  chk_level_now: assert property (wr &&
    bus_req_in.addr == tmw_pkg::OFF_OUT_CTRL |=>
    capture_compare_pin_a_out == $past(wd[0]))
    else $error("pin level not updated");
  chk_rd_idle: assert property (ce_in && !bus_req_in.rd |=>
    rd_data_out == 16'h0000)
    else $error("read data outside read slot");
  chk_flag_sticky: assert property (match_irq_a_out && ce_in && !st_wr
    && !en_wr |=> match_irq_a_out)
    else $error("match a flag dropped by itself");
  chk_reset_vals: assert property (disable iff (1'b0) sys_rst_in && ce_in
    |=> !timer_irq_out && !capture_compare_pin_a_out
    && capture_compare_pin_a_oe_out)
    else $error("reset values wrong");

  cov_ovf: cover property (overflow_irq_out);
  cov_match_a: cover property (match_irq_a_out);
  cov_en_rd: cover property (ce_in && bus_req_in.rd);
endmodule : tmw_timer_irq_chk

bind tmw_timer_irq tmw_timer_irq_chk #(.W(W)) u_chk (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
  .bus_req_in(bus_req_in), .rd_data_out(rd_data_out),
  .capture_compare_pin_a_out(capture_compare_pin_a_out),
  .capture_compare_pin_a_oe_out(capture_compare_pin_a_oe_out),
  .overflow_irq_out(overflow_irq_out), .match_irq_a_out(match_irq_a_out),
  .match_irq_b_out(match_irq_b_out), .match_irq_c_out(match_irq_c_out),
  .match_irq_d_out(match_irq_d_out), .timer_irq_out(timer_irq_out));

// file: test/test_timer_irq_enable_and_out_level.sv
`timescale 1ns/1ps
module test_timer_irq_enable_and_out_level;
  logic                  mclk_in = 1'b0;
  logic                  sys_rst_in = 1'b1;
  tmw_pkg::tmw_bus_req_t req = '0;
  logic [3:0]            pins = 4'h0;
  logic [15:0]           rd;
  logic                  pin_a, oe_a, ovf, ia, ib, ic, id, irq;
  logic [7:0]            irq_edges;
  int                    fails = 0;
  int                    checks = 0;
  int                    m_en = 0;
  int                    m_flags = 0;
  logic [15:0]           v;
  logic                  ce = 1'b1;
  logic [7:0]            e0;

  always #20 mclk_in = ~mclk_in;

  tmw_timer_irq dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .ce_in(ce), .bus_req_in(req), .rd_data_out(rd),
    .capture_compare_pin_in(pins), .capture_compare_pin_a_out(pin_a),
    .capture_compare_pin_a_oe_out(oe_a), .overflow_irq_out(ovf),
    .match_irq_a_out(ia), .match_irq_b_out(ib), .match_irq_c_out(ic),
    .match_irq_d_out(id), .timer_irq_out(irq));
  tmw_intc_model u_intc (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .irq_in(irq), .edges_out(irq_edges));

  task automatic finish_test;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp16

  task automatic cmp_sig(input logic [5:0] got, input logic [5:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_sig

  task automatic bus(input logic [7:0] a, input logic [15:0] d, input logic w);
    @(posedge mclk_in);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge mclk_in);
    req <= '0;
    #1;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    bus(a, 16'h0000, 1'b0);
    cmp16(rd, exp);
  endtask : rd_chk

  task automatic irq_chk;
    logic [7:0] f;
    f = 8'(m_flags & m_en);
    cmp_sig({ovf, id, ic, ib, ia, irq}, {f[7], f[3:0], |{f[7], f[3:0]}});
  endtask : irq_chk

  initial begin
    repeat (20000) @(posedge mclk_in);
    fails++;
    finish_test();
  end

  initial begin
    void'($urandom(32'hCCA4));
    repeat (8) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd_chk(tmw_pkg::OFF_IRQ_EN, 16'h0070);
    rd_chk(tmw_pkg::OFF_STATUS, 16'h0070);
    rd_chk(8'h3C, 16'h0000);
    cmp_sig({4'h0, oe_a, pin_a}, 6'h02);
    for (int i = 0; i < 6; i++) begin
      v = 16'($urandom);
      m_en = v & 16'h008F;
      bus(tmw_pkg::OFF_IRQ_EN, v, 1'b1);
      rd_chk(tmw_pkg::OFF_IRQ_EN, 16'(m_en | 16'h0070));
    end
    for (int lv = 1; lv >= 0; lv--) begin
      bus(tmw_pkg::OFF_OUT_CTRL, 16'(lv), 1'b1);
      cmp_sig({5'h00, pin_a}, 6'(lv));
    end
    bus(tmw_pkg::OFF_COUNT, 16'hFFFD, 1'b1);
    bus(tmw_pkg::OFF_OUT_CTRL, 16'h0081, 1'b1);
    repeat (8) @(posedge mclk_in);
    m_flags = 16'h008F;
    rd_chk(tmw_pkg::OFF_STATUS, 16'h00FF);
    cmp_sig({5'h00, pin_a}, 6'h01);
    for (int i = 0; i < 5; i++) begin
      m_en = (i == 4) ? 16'h0080 : (1 << i);
      bus(tmw_pkg::OFF_IRQ_EN, 16'(m_en), 1'b1);
      irq_chk();
    end
    m_en = 16'h008F;
    bus(tmw_pkg::OFF_IRQ_EN, 16'h008F, 1'b1);
    bus(tmw_pkg::OFF_STATUS, 16'h00FF, 1'b1);
    bus(tmw_pkg::OFF_STATUS, 16'h0000, 1'b1);
    rd_chk(tmw_pkg::OFF_STATUS, 16'h00FF);
    bus(tmw_pkg::OFF_STATUS, 16'h00FE, 1'b1);
    m_flags = 16'h008E;
    rd_chk(tmw_pkg::OFF_STATUS, 16'h00FE);
    irq_chk();
    bus(tmw_pkg::OFF_STATUS, 16'h0000, 1'b1);
    m_flags = 0;
    rd_chk(tmw_pkg::OFF_STATUS, 16'h0070);
    irq_chk();
    e0 = irq_edges;
    bus(tmw_pkg::OFF_CH_MODE, 16'h0001, 1'b1);
    cmp_sig({5'h00, oe_a}, 6'h00);
    @(posedge mclk_in);
    pins <= 4'h3;
    repeat (6) @(posedge mclk_in);
    m_flags = 16'h0001;
    rd_chk(tmw_pkg::OFF_STATUS, 16'h0071);
    irq_chk();
    @(posedge mclk_in);
    ce <= 1'b0;
    bus(tmw_pkg::OFF_IRQ_EN, 16'h0000, 1'b1);
    @(posedge mclk_in);
    ce <= 1'b1;
    #1;
    irq_chk();
    bus(tmw_pkg::OFF_CH_MODE, 16'h0022, 1'b1);
    bus(tmw_pkg::OFF_COUNT, 16'h0100, 1'b1);
    bus(tmw_pkg::OFF_GR_A, 16'h0140, 1'b1);
    bus(tmw_pkg::OFF_OUT_CTRL, 16'h0087, 1'b1);
    @(posedge mclk_in);
    pins <= 4'h1;
    repeat (80) @(posedge mclk_in);
    m_flags = 16'h0003;
    rd_chk(tmw_pkg::OFF_STATUS, 16'h0073);
    cmp_sig({4'h0, oe_a, pin_a}, 6'h02);
    irq_chk();
    cmp16(16'(irq_edges - e0), 16'h0001);
    finish_test();
  end
endmodule : test_timer_irq_enable_and_out_level
